/* File: hw/sbci_defines.svh */
// constants of the serial boot command interpreter
`ifndef SBCI_DEFINES_SVH
`define SBCI_DEFINES_SVH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define SBCI_OP_PAGE_READ 8'hff
`define SBCI_OP_PAGE_PROG 8'h41
`define SBCI_OP_ERASE_ALL 8'ha7
`define SBCI_OP_CONFIRM 8'hd0
`define SBCI_OP_READ_STAT 8'h70
`define SBCI_OP_CLEAR_STAT 8'h50
`define SBCI_OP_ID_CHECK 8'hf5
`define SBCI_OP_DOWNLOAD 8'hfa
`define SBCI_OP_VERSION 8'hfb
`define SBCI_OP_BOOT_READ 8'hfc

// ----------------------------------------
// counts and reset values
// ----------------------------------------
`define SBCI_PAGE_LAST 8'hff
`define SBCI_VER_LAST 3'h7
`define SBCI_ID_VERIFIED 2'h3
`define SBCI_ID_MISMATCH 2'h1
`define SBCI_ID_NONE 2'h0
// version text, eight ascii characters, value arbitrary
`define SBCI_VERSION_TEXT 64'h31302e3030524556

// ----------------------------------------
// status byte field positions
// ----------------------------------------
`define SBCI_FS_READY 7
`define SBCI_FS_ERASE_ERR 5
`define SBCI_FS_PROG_ERR 4
`define SBCI_LS_UPDATED 7
`define SBCI_LS_SUM_OK 4
`define SBCI_LS_ID_HI 3
`define SBCI_LS_ID_LO 2

`endif

/* File: hw/sbci_pkg.sv */
// types of the serial boot command interpreter
package sbci_pkg;

    // ----------------------------------------
    // interpreter phases, gray along the usual path
    // ----------------------------------------
    typedef enum logic [1:0] {
        SBCI_CMD = 2'h0,
        SBCI_ARG = 2'h1,
        SBCI_XFER = 2'h3,
        SBCI_FLASH = 2'h2
    } sbci_phase_t;

    typedef enum logic [1:0] {
        SBCI_FL_READ = 2'h0,
        SBCI_FL_PROG = 2'h1,
        SBCI_FL_ERASE = 2'h2,
        SBCI_FL_NONE = 2'h3
    } sbci_flop_t;

    // ----------------------------------------
    // core state
    // ----------------------------------------
    typedef struct packed {
        sbci_phase_t phase;
        logic [7:0] opc;
        logic [1:0] argn;
        logic [7:0] addr_low;
        logic [7:0] addr_mid;
        logic [15:0] size;
        logic [15:0] cnt;
        logic [7:0] csum;
        logic [7:0] sum;
        logic [7:0] id_size;
        logic id_ok;
        logic seen;
        logic erase_error_flag;
        logic prog_error_flag;
        logic error_flag_low;
        logic updated;
        logic sum_ok;
        logic [1:0] id_state;
        logic [7:0] tx_byte;
        logic busy;
        logic flash_req;
        sbci_flop_t flash_op;
        logic [15:0] flash_addr;
        logic flash_boot;
        logic [7:0] flash_wdata;
        logic ram_we;
        logic [15:0] ram_addr;
        logic [7:0] ram_wdata;
        logic run_ram;
    } sbci_core_t;

    // ----------------------------------------
    // link state, one per clock edge
    // ----------------------------------------
    typedef struct packed {
        logic [6:0] sh;
        logic [2:0] cnt;
        logic [7:0] rx_byte;
        logic rx_tgl;
    } sbci_rise_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic txd;
    } sbci_fall_t;

endpackage

/* File: hw/sbci_link_if.sv */
// byte carrier between the link logic and the interpreter core
`timescale 1ns/1ps
interface sbci_link_if;
    logic [7:0] rx_byte;
    logic rx_tgl;
    logic [7:0] tx_byte;

    modport link (
        output rx_byte,
        output rx_tgl,
        input tx_byte
    );

    modport core (
        input rx_byte,
        input rx_tgl,
        output tx_byte
    );
endinterface

/* File: hw/sbci_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sbci_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic [1:0] st;
    logic [1:0] next_st;

    always_comb begin
        next_st = rst ? 2'h0 : {st[0], d};
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign q = st[1];
endmodule

/* File: hw/sbci_link.sv */
// shift logic on the transfer clock
`timescale 1ns/1ps
`include "sbci_defines.svh"
module sbci_link (
    input wire logic sclk,
    input wire logic rst_link,
    input wire logic rxd,
    output logic txd,
    sbci_link_if.link lnk
);
    sbci_pkg::sbci_rise_t r;
    sbci_pkg::sbci_rise_t next_r;
    sbci_pkg::sbci_fall_t f;
    sbci_pkg::sbci_fall_t next_f;

    // ----------------------------------------
    // receive on rising edges, lsb first
    // ----------------------------------------
    always_comb begin
        next_r = r;
        next_r.sh = {rxd, r.sh[6:1]};
        next_r.cnt = r.cnt + 3'h1;
        if (r.cnt == 3'h7) begin
            next_r.rx_byte = {rxd, r.sh};
            next_r.rx_tgl = ~r.rx_tgl;
        end
        if (rst_link) begin
            next_r = '0;
        end
    end

    always_ff @(posedge sclk) begin
        r <= next_r;
    end

    // ----------------------------------------
    // transmit on falling edges
    // ----------------------------------------
    // tx_byte is held by the core while busy is low, so it is stable here
    always_comb begin
        next_f = f;
        next_f.txd = lnk.tx_byte[f.cnt];
        next_f.cnt = f.cnt + 3'h1;
        if (rst_link) begin
            next_f = '0;
        end
    end

    always_ff @(negedge sclk) begin
        f <= next_f;
    end

    assign txd = f.txd;
    assign lnk.rx_byte = r.rx_byte;
    assign lnk.rx_tgl = r.rx_tgl;
endmodule

/* File: hw/sbci_top.sv */
// serial boot command interpreter, top level and command core
// Notes on behaviour
// - page read: ff, middle and high address, then 256 bytes out ascending
// - page program: 41, middle and high address, 256 bytes in, written ascending
// - after each programmed byte busy falls when ready for more data
// - erase all: a7 then d0; only d0 starts the full erase
// - busy falls when the full erase ends; result in flash status byte
// - opcode 70 returns flash status then link status byte
// - opcode 50 clears error flag bits three to five
// - busy falls once the clear has finished
// - no block erase; id check f5 with low, middle, high, size, id bytes
// - unverified: only status read, id check and version are accepted
// - blank flash accepts every command
// - program bytes are summed and compared with the checksum
// - loaded program runs only on checksum match
// - opcode fb returns eight ascii version characters
// - boot read: fc, middle and high address, 256 boot bytes ascending
// - every transfer is eight bits, lsb first
// - sample on rising transfer clock, shift out on falling
// - non-blank flash rejects commands until the id matches
`timescale 1ns/1ps
`include "sbci_defines.svh"
module sbci_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic rxd,
    output logic txd,
    output logic busy_ready_out,
    output logic flash_req,
    output logic [1:0] flash_op,
    output logic [15:0] flash_addr,
    output logic flash_boot,
    output logic [7:0] flash_wdata,
    input wire logic flash_done,
    input wire logic flash_err,
    input wire logic [7:0] flash_rdata,
    input wire logic flash_blank,
    output logic ram_we,
    output logic [15:0] ram_addr,
    output logic [7:0] ram_wdata,
    output logic run_ram
);
    localparam logic [63:0] VERSION_TEXT = `SBCI_VERSION_TEXT;

    sbci_pkg::sbci_core_t s;
    sbci_pkg::sbci_core_t next_s;
    logic rst_link;
    logic rx_tgl_sync;
    logic [7:0] flash_status_byte;
    logic [7:0] link_status_byte;
    logic unlocked;
    logic ev;
    logic [7:0] b;
    logic [7:0] sum_new;

    sbci_link_if lnk ();

    // ----------------------------------------
    // link domain and crossings
    // ----------------------------------------
    sbci_sync u_rst_sync (
        .clk(sclk),
        .rst(1'b0),
        .d(rst),
        .q(rst_link)
    );

    sbci_link u_link (
        .sclk(sclk),
        .rst_link(rst_link),
        .rxd(rxd),
        .txd(txd),
        .lnk(lnk.link)
    );

    // the byte itself is read only after its toggle has crossed
    sbci_sync u_rx_sync (
        .clk(clk),
        .rst(rst),
        .d(lnk.rx_tgl),
        .q(rx_tgl_sync)
    );

    assign lnk.tx_byte = s.tx_byte;

    // ----------------------------------------
    // status bytes and command gate
    // ----------------------------------------
    always_comb begin
        flash_status_byte = 8'h00;
        flash_status_byte[`SBCI_FS_READY] = (s.phase != sbci_pkg::SBCI_FLASH);
        flash_status_byte[`SBCI_FS_ERASE_ERR] = s.erase_error_flag;
        flash_status_byte[`SBCI_FS_PROG_ERR] = s.prog_error_flag;
        flash_status_byte[3] = s.error_flag_low;
        link_status_byte = 8'h00;
        link_status_byte[`SBCI_LS_UPDATED] = s.updated;
        link_status_byte[`SBCI_LS_SUM_OK] = s.sum_ok;
        link_status_byte[`SBCI_LS_ID_HI:`SBCI_LS_ID_LO] = s.id_state;
    end

    assign unlocked = flash_blank || (s.id_state == `SBCI_ID_VERIFIED);
    assign ev = (rx_tgl_sync != s.seen);
    assign b = lnk.rx_byte;
    assign sum_new = s.sum + b;

    // ----------------------------------------
    // command core
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.flash_req = 1'b0;
        next_s.ram_we = 1'b0;
        next_s.run_ram = 1'b0;
        if (ev) begin
            next_s.seen = rx_tgl_sync;
        end
        unique case (s.phase)
            sbci_pkg::SBCI_CMD: begin
                if (ev) begin
                    next_s.opc = b;
                    next_s.argn = 2'h0;
                    next_s.cnt = 16'h0000;
                    case (b)
                        `SBCI_OP_READ_STAT: begin
                            next_s.tx_byte = flash_status_byte;
                            next_s.phase = sbci_pkg::SBCI_XFER;
                        end
                        `SBCI_OP_VERSION: begin
                            next_s.tx_byte = VERSION_TEXT[7:0];
                            next_s.phase = sbci_pkg::SBCI_XFER;
                        end
                        `SBCI_OP_ID_CHECK: begin
                            next_s.phase = sbci_pkg::SBCI_ARG;
                        end
                        `SBCI_OP_CLEAR_STAT: begin
                            if (unlocked) begin
                                next_s.erase_error_flag = 1'b0;
                                next_s.prog_error_flag = 1'b0;
                                next_s.error_flag_low = 1'b0;
                            end
                        end
                        `SBCI_OP_PAGE_READ, `SBCI_OP_PAGE_PROG, `SBCI_OP_ERASE_ALL,
                        `SBCI_OP_DOWNLOAD, `SBCI_OP_BOOT_READ: begin
                            if (unlocked) begin
                                next_s.phase = sbci_pkg::SBCI_ARG;
                            end
                        end
                        default: begin
                            next_s.phase = sbci_pkg::SBCI_CMD;
                        end
                    endcase
                end
            end
            sbci_pkg::SBCI_ARG: begin
                if (ev) begin
                    next_s.argn = s.argn + 2'h1;
                    case (s.opc)
                        `SBCI_OP_PAGE_READ, `SBCI_OP_BOOT_READ, `SBCI_OP_PAGE_PROG: begin
                            if (s.argn == 2'h0) begin
                                next_s.addr_mid = b;
                            end else if (s.opc == `SBCI_OP_PAGE_PROG) begin
                                next_s.phase = sbci_pkg::SBCI_XFER;
                            end else begin
                                // high byte is zero by contract, so it is not stored
                                next_s.flash_req = 1'b1;
                                next_s.flash_op = sbci_pkg::SBCI_FL_READ;
                                next_s.flash_addr = {s.addr_mid, 8'h00};
                                next_s.flash_boot = (s.opc == `SBCI_OP_BOOT_READ);
                                next_s.phase = sbci_pkg::SBCI_FLASH;
                            end
                        end
                        `SBCI_OP_ERASE_ALL: begin
                            if (b == `SBCI_OP_CONFIRM) begin
                                next_s.flash_req = 1'b1;
                                next_s.flash_op = sbci_pkg::SBCI_FL_ERASE;
                                next_s.flash_boot = 1'b0;
                                next_s.phase = sbci_pkg::SBCI_FLASH;
                            end else begin
                                next_s.phase = sbci_pkg::SBCI_CMD;
                            end
                        end
                        `SBCI_OP_ID_CHECK: begin
                            if (s.argn == 2'h0) begin
                                next_s.addr_low = b;
                            end else if (s.argn == 2'h1) begin
                                next_s.addr_mid = b;
                            end else if (s.argn == 2'h3) begin
                                next_s.id_size = b;
                                next_s.id_ok = 1'b1;
                                if (b == 8'h00) begin
                                    next_s.id_state = `SBCI_ID_MISMATCH;
                                    next_s.phase = sbci_pkg::SBCI_CMD;
                                end else begin
                                    next_s.phase = sbci_pkg::SBCI_XFER;
                                end
                            end
                        end
                        default: begin
                            // download header
                            if (s.argn == 2'h0) begin
                                next_s.size[7:0] = b;
                            end else if (s.argn == 2'h1) begin
                                next_s.size[15:8] = b;
                            end else begin
                                next_s.csum = b;
                                next_s.sum = 8'h00;
                                if (s.size == 16'h0000) begin
                                    next_s.phase = sbci_pkg::SBCI_CMD;
                                end else begin
                                    next_s.phase = sbci_pkg::SBCI_XFER;
                                end
                            end
                        end
                    endcase
                end
            end
            sbci_pkg::SBCI_XFER: begin
                if (ev) begin
                    case (s.opc)
                        `SBCI_OP_READ_STAT: begin
                            next_s.cnt = s.cnt + 16'h0001;
                            next_s.tx_byte = link_status_byte;
                            if (s.cnt[0]) begin
                                next_s.phase = sbci_pkg::SBCI_CMD;
                            end
                        end
                        `SBCI_OP_VERSION: begin
                            next_s.cnt = s.cnt + 16'h0001;
                            // no char after the last one, the slice would run past the text
                            if (s.cnt[2:0] == `SBCI_VER_LAST) begin
                                next_s.phase = sbci_pkg::SBCI_CMD;
                            end else begin
                                next_s.tx_byte = VERSION_TEXT[8 * (s.cnt[2:0] + 3'h1) +: 8];
                            end
                        end
                        `SBCI_OP_PAGE_READ, `SBCI_OP_BOOT_READ: begin
                            if (s.cnt[7:0] == `SBCI_PAGE_LAST) begin
                                next_s.phase = sbci_pkg::SBCI_CMD;
                            end else begin
                                next_s.cnt = s.cnt + 16'h0001;
                                next_s.flash_req = 1'b1;
                                next_s.flash_op = sbci_pkg::SBCI_FL_READ;
                                next_s.flash_addr = {s.addr_mid, s.cnt[7:0] + 8'h01};
                                next_s.phase = sbci_pkg::SBCI_FLASH;
                            end
                        end
                        `SBCI_OP_PAGE_PROG: begin
                            next_s.flash_req = 1'b1;
                            next_s.flash_op = sbci_pkg::SBCI_FL_PROG;
                            next_s.flash_addr = {s.addr_mid, s.cnt[7:0]};
                            next_s.flash_boot = 1'b0;
                            next_s.flash_wdata = b;
                            next_s.phase = sbci_pkg::SBCI_FLASH;
                        end
                        `SBCI_OP_ID_CHECK: begin
                            // stored code is fetched byte by byte and compared on return
                            next_s.flash_req = 1'b1;
                            next_s.flash_op = sbci_pkg::SBCI_FL_READ;
                            next_s.flash_addr = {s.addr_mid, s.addr_low} + s.cnt;
                            next_s.flash_boot = 1'b0;
                            next_s.flash_wdata = b;
                            next_s.phase = sbci_pkg::SBCI_FLASH;
                        end
                        default: begin
                            next_s.ram_we = 1'b1;
                            next_s.ram_addr = s.cnt;
                            next_s.ram_wdata = b;
                            next_s.sum = sum_new;
                            next_s.cnt = s.cnt + 16'h0001;
                            if (s.cnt + 16'h0001 == s.size) begin
                                next_s.sum_ok = (sum_new == s.csum);
                                next_s.updated = (sum_new == s.csum);
                                next_s.run_ram = (sum_new == s.csum);
                                next_s.phase = sbci_pkg::SBCI_CMD;
                            end
                        end
                    endcase
                end
            end
            sbci_pkg::SBCI_FLASH: begin
                if (flash_done) begin
                    case (s.opc)
                        `SBCI_OP_PAGE_PROG: begin
                            if (flash_err) begin
                                next_s.prog_error_flag = 1'b1;
                            end
                            next_s.cnt = s.cnt + 16'h0001;
                            if (s.cnt[7:0] == `SBCI_PAGE_LAST) begin
                                next_s.phase = sbci_pkg::SBCI_CMD;
                            end else begin
                                next_s.phase = sbci_pkg::SBCI_XFER;
                            end
                        end
                        `SBCI_OP_ERASE_ALL: begin
                            next_s.erase_error_flag = s.erase_error_flag | flash_err;
                            next_s.phase = sbci_pkg::SBCI_CMD;
                        end
                        `SBCI_OP_ID_CHECK: begin
                            next_s.cnt = s.cnt + 16'h0001;
                            if ((s.cnt[7:0] + 8'h01) == s.id_size) begin
                                if (s.id_ok && (flash_rdata == s.flash_wdata)) begin
                                    next_s.id_state = `SBCI_ID_VERIFIED;
                                end else begin
                                    next_s.id_state = `SBCI_ID_MISMATCH;
                                end
                                next_s.phase = sbci_pkg::SBCI_CMD;
                            end else begin
                                next_s.id_ok = s.id_ok && (flash_rdata == s.flash_wdata);
                                next_s.phase = sbci_pkg::SBCI_XFER;
                            end
                        end
                        default: begin
                            next_s.tx_byte = flash_rdata;
                            next_s.phase = sbci_pkg::SBCI_XFER;
                        end
                    endcase
                end
            end
        endcase
        // busy pulses for each byte taken and stands while flash works
        next_s.busy = ev || (next_s.phase == sbci_pkg::SBCI_FLASH);
        if (rst) begin
            next_s = '0;
            next_s.flash_op = sbci_pkg::SBCI_FL_NONE;
            next_s.id_state = `SBCI_ID_NONE;
        end
    end

    always_ff @(posedge clk) begin
        s <= next_s;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign busy_ready_out = s.busy;
    assign flash_req = s.flash_req;
    assign flash_op = s.flash_op;
    assign flash_addr = s.flash_addr;
    assign flash_boot = s.flash_boot;
    assign flash_wdata = s.flash_wdata;
    assign ram_we = s.ram_we;
    assign ram_addr = s.ram_addr;
    assign ram_wdata = s.ram_wdata;
    assign run_ram = s.run_ram;
endmodule

/* File: bench/sbci_checker.sv */
// assertions and covers on the interpreter top ports
`timescale 1ns/1ps
module sbci_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic busy_ready_out,
    input wire logic flash_req,
    input wire logic [1:0] flash_op,
    input wire logic [15:0] flash_addr,
    input wire logic flash_boot,
    input wire logic flash_done,
    input wire logic ram_we,
    input wire logic run_ram
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------
    // assertions
    // ----------------
    chk_req_busy: assert property (flash_req |=> busy_ready_out)
        else $error("request while ready");
    chk_done_ready: assert property (flash_done |=> !busy_ready_out)
        else $error("busy after done");
    chk_busy_bound: assert property ($rose(busy_ready_out) |-> ##[1:12] !busy_ready_out)
        else $error("busy stuck");
    chk_req_single: assert property (flash_req |=> !flash_req)
        else $error("double request");
    chk_addr_holds: assert property (!flash_req |-> $stable(flash_addr) && $stable(flash_op))
        else $error("address moved");
    chk_boot_read: assert property (flash_req && flash_boot |-> flash_op == 2'h0)
        else $error("boot access not read");
    chk_run_last: assert property (run_ram |-> ram_we)
        else $error("start without byte");
    chk_run_once: assert property (run_ram |=> !run_ram [*8])
        else $error("start repeated");
    cover property (run_ram);
    cover property (flash_req && flash_op == 2'h2);
    cover property (flash_req && flash_boot);
endmodule
bind sbci_top sbci_checker u_chk (.clk, .rst, .busy_ready_out, .flash_req, .flash_op, .flash_addr, .flash_boot,
    .flash_done, .ram_we, .run_ram);

/* File: bench/sbci_prog_model.sv */
// serial programmer model, owns the transfer clock
`timescale 1ns/1ps
module sbci_prog_model (
    input wire logic clk,
    input wire logic busy,
    input wire logic txd,
    output logic sclk,
    output logic rxd
);
    initial begin
        sclk = 1'b1;
        rxd = 1'b0;
    end
    // bare clock pulses for the link reset sync
    task automatic kick(input int n);
        repeat (n) begin
            #3 sclk = 1'b0;
            #3 sclk = 1'b1;
        end
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        for (int i = 0; i < 8; i++) begin
            #3 sclk = 1'b0;
            rxd = d[i];
            #3 sclk = 1'b1;
            q[i] = txd;
        end
        #1 rxd = ~rxd;
        // wait past the crossing, then for ready
        repeat (6) @(negedge clk);
        while (busy) @(negedge clk);
    endtask
endmodule

/* File: bench/tb_sbci.sv */
// self-checking bench of the serial boot command interpreter
`timescale 1ns/1ps
`include "sbci_defines.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_sbci;
    logic clk = 1'b0, rst = 1'b1, flash_done = 1'b0, flash_err = 1'b0, flash_blank = 1'b0, err_inj = 1'b0;
    logic sclk, rxd, txd, busy_ready_out, flash_req, flash_boot, ram_we, run_ram;
    logic [1:0] flash_op;
    logic [15:0] flash_addr, ram_addr;
    logic [7:0] flash_wdata, ram_wdata, q, sum, mid, flash_rdata = 8'h00;
    logic [7:0] dat [5];
    integer seed = 31900;
    int dly = 0, nreq = 0, nwe = 0, nrun = 0, cyc = 0, failures = 0, total_checks = 0;
    always #50 clk = ~clk;
    sbci_top i_dut (.clk, .rst, .sclk, .rxd, .txd, .busy_ready_out, .flash_req, .flash_op, .flash_addr, .flash_boot,
        .flash_wdata, .flash_done, .flash_err, .flash_rdata, .flash_blank, .ram_we, .ram_addr, .ram_wdata, .run_ram);
    sbci_prog_model u_prog (.clk, .busy(busy_ready_out), .txd, .sclk, .rxd);
    function automatic logic [7:0] exp_rd(input logic [15:0] a, input logic b);
        return a[7:0] ^ a[15:8] ^ {b, 7'h15};
    endfunction
    task automatic give_verdict();
        if (failures == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // flash stand-in, random answer delay
    always @(negedge clk) begin
        flash_done <= !flash_req && dly == 1;
        nwe = nwe + ram_we;
        nrun = nrun + run_ram;
        if (ram_we) `CHK("ram data", dat[ram_addr[2:0]], ram_wdata)
        if (flash_req) begin
            nreq = nreq + 1;
            dly = 2 + {$random(seed)} % 3;
            if (flash_op == 2'h1) `CHK("prog data", exp_rd(flash_addr, 1'b0), flash_wdata)
        end else if (dly > 0) begin
            dly = dly - 1;
            if (dly == 0) begin
                flash_rdata <= exp_rd(flash_addr, flash_boot);
                flash_err <= err_inj && flash_op != 2'h0;
            end
        end
    end
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            failures = failures + 1;
            give_verdict();
        end
    end
    initial begin
        u_prog.kick(4);
        repeat (10) @(negedge clk);
        rst = 1'b0;
        u_prog.kick(2);
        repeat (4) @(negedge clk);
        // locked and not blank
        u_prog.xfer(`SBCI_OP_PAGE_READ, q);
        u_prog.xfer(`SBCI_OP_ERASE_ALL, q);
        u_prog.xfer(`SBCI_OP_CONFIRM, q);
        `CHK("locked", 0, nreq)
        flash_blank = 1'b1;
        err_inj = 1'b1;
        u_prog.xfer(`SBCI_OP_ERASE_ALL, q);
        `CHK("erase early", 0, nreq)
        u_prog.xfer(`SBCI_OP_CONFIRM, q);
        `CHK("erase", 1, nreq)
        u_prog.xfer(`SBCI_OP_VERSION, q);
        for (int k = 0; k < 8; k++) begin
            u_prog.xfer(8'h00, q);
            `CHK("version", 8'(`SBCI_VERSION_TEXT >> (8 * k)), q)
        end
        for (int k = 0; k < 2; k++) begin
            mid = 8'($random(seed));
            u_prog.xfer(k ? `SBCI_OP_BOOT_READ : `SBCI_OP_PAGE_READ, q);
            u_prog.xfer(mid, q);
            u_prog.xfer(8'h00, q);
            for (int a = 0; a < 256; a++) begin
                u_prog.xfer(8'h00, q);
                `CHK("page", exp_rd({mid, 8'(a)}, 1'(k)), q)
            end
        end
        // second download carries a wrong checksum
        for (int k = 0; k < 2; k++) begin
            sum = 8'h00;
            foreach (dat[i]) begin
                dat[i] = 8'($random(seed));
                sum = sum + dat[i];
            end
            u_prog.xfer(`SBCI_OP_DOWNLOAD, q);
            u_prog.xfer(8'h05, q);
            u_prog.xfer(8'h00, q);
            u_prog.xfer(sum + 8'(k), q);
            foreach (dat[i]) u_prog.xfer(dat[i], q);
            `CHK("ram writes", 5 * (k + 1), nwe)
            `CHK("started", 1, nrun)
        end
        // locked again, opened by a matching id, then a page program with error
        flash_blank = 1'b0;
        u_prog.xfer(`SBCI_OP_ID_CHECK, q);
        for (int i = 0; i < 3; i++) u_prog.xfer(8'h00, q);
        u_prog.xfer(8'h02, q);
        for (int i = 0; i < 2; i++) u_prog.xfer(exp_rd(16'(i), 1'b0), q);
        u_prog.xfer(`SBCI_OP_PAGE_PROG, q);
        u_prog.xfer(mid, q);
        u_prog.xfer(8'h00, q);
        for (int a = 0; a < 256; a++) u_prog.xfer(exp_rd({mid, 8'(a)}, 1'b0), q);
        `CHK("requests", 771, nreq)
        for (int k = 0; k < 2; k++) begin
            u_prog.xfer(`SBCI_OP_READ_STAT, q);
            u_prog.xfer(8'h00, q);
            `CHK("flash status", k ? 8'h80 : 8'hb0, q)
            u_prog.xfer(8'h00, q);
            `CHK("link status", 8'h0c, q)
            u_prog.xfer(`SBCI_OP_CLEAR_STAT, q);
        end
        give_verdict();
    end
endmodule
